/* File: common/bpab_pkg.sv */
// package: register map, field layout and bus codes of the two-port gpio block
package bpab_pkg;
  localparam int unsigned BPAB_DATA_W = 32;
  localparam int unsigned BPAB_WIDE_W = 8;
  localparam int unsigned BPAB_NARROW_W = 3;
  localparam int unsigned BPAB_SYNC_W = BPAB_WIDE_W + BPAB_NARROW_W;
  // register indices; byte address is four times the index
  localparam logic [7:0] BPAB_IDX_WIDE_DATA = 8'h00;
  localparam logic [7:0] BPAB_IDX_NARROW_DATA = 8'h01;
  localparam logic [7:0] BPAB_IDX_WIDE_DIR = 8'h04;
  localparam logic [7:0] BPAB_IDX_NARROW_DIR = 8'h05;
  localparam logic [7:0] BPAB_IDX_KEYPAD_EN = 8'h17;
  localparam logic [7:0] BPAB_IDX_PIN_OPT = 8'h1a;
  localparam logic [7:0] BPAB_IDX_PULLUP = 8'h3e;
  // narrow port pins sit at these bit positions of its registers
  localparam int unsigned BPAB_NB_POS0 = 0;
  localparam int unsigned BPAB_NB_POS1 = 1;
  localparam int unsigned BPAB_NB_POS2 = 5;
  localparam logic [7:0] BPAB_DIR_RESET = 8'h00;
  localparam logic [7:0] BPAB_CTRL_RESET = 8'h00;
  localparam int unsigned BPAB_WIDE_DIR7 = 7;
  localparam logic [1:0] BPAB_RESP_OKAY = 2'h0;
  localparam logic [1:0] BPAB_RESP_SLVERR = 2'h2;
  typedef enum logic [6:0] {
    BPAB_R_WIDE_DATA = 7'h01,
    BPAB_R_NARROW_DATA = 7'h02,
    BPAB_R_WIDE_DIR = 7'h04,
    BPAB_R_NARROW_DIR = 7'h08,
    BPAB_R_KEYPAD_EN = 7'h10,
    BPAB_R_PIN_OPT = 7'h20,
    BPAB_R_PULLUP = 7'h40
  } bpab_reg_t;
endpackage

/* File: common/bpab_sync_if.sv */
// interface: raw pin levels in, synchronised levels out
`timescale 1ns/1ps
`default_nettype none
interface bpab_sync_if #(parameter int unsigned W = 11);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport src (output raw, input sync);
  modport dst (input raw, output sync);
endinterface
`default_nettype wire

/* File: hw/bpab_pin_sync.sv */
// two-flop synchroniser for the pin levels
`timescale 1ns/1ps
`default_nettype none
module bpab_pin_sync #(
  parameter int unsigned W = 11
) (
  input wire logic clock,
  input wire logic sys_rst,
  bpab_sync_if.dst sif
);
  import bpab_pkg::*;
  logic [W-1:0] meta_q, meta_d, sync_q, sync_d;

  always_comb begin
    meta_d = sif.raw;
    sync_d = meta_q;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sif.sync = sync_q;

  a_sync_two_stage: assert property (@(posedge clock) disable iff (sys_rst)
    $past(!sys_rst, 2) |-> sync_q == $past(sif.raw, 2))
    else $error("synchronised level does not lag the pin by two clocks");
endmodule // bpab_pin_sync
`default_nettype wire

/* File: hw/bpab_top.sv */
// top: two-port gpio with axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
module bpab_top #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic por_lvr_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [bpab_pkg::BPAB_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  output var logic [bpab_pkg::BPAB_DATA_W-1:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [bpab_pkg::BPAB_WIDE_W-1:0] wide_pin_in,
  output var logic [bpab_pkg::BPAB_WIDE_W-1:0] wide_pin_out,
  output var logic [bpab_pkg::BPAB_WIDE_W-1:0] wide_pin_oe_n,
  output var logic [bpab_pkg::BPAB_WIDE_W-1:0] wide_pullup_en,
  output var logic [bpab_pkg::BPAB_WIDE_W-1:0] keypad_irq_inputs,
  input wire logic [bpab_pkg::BPAB_NARROW_W-1:0] narrow_pin_in,
  output var logic [bpab_pkg::BPAB_NARROW_W-1:0] narrow_pin_out,
  output var logic [bpab_pkg::BPAB_NARROW_W-1:0] narrow_pin_oe_n,
  output var logic [bpab_pkg::BPAB_NARROW_W-1:0] narrow_pullup_en,
  output var logic [bpab_pkg::BPAB_NARROW_W-1:0] led_direct_drive
);
  import bpab_pkg::*;

  if (ADDR_W < 8 || ADDR_W > 16) begin : g_chk
    $error("ADDR_W must be 8 to 16");
  end

  // narrow register byte to pin vector and back
  function automatic logic [BPAB_NARROW_W-1:0] nb_unpack(input logic [7:0] v);
    nb_unpack = {v[BPAB_NB_POS2], v[BPAB_NB_POS1], v[BPAB_NB_POS0]};
  endfunction

  function automatic logic [7:0] nb_pack(input logic [BPAB_NARROW_W-1:0] v);
    nb_pack = '0;
    nb_pack[BPAB_NB_POS0] = v[0];
    nb_pack[BPAB_NB_POS1] = v[1];
    nb_pack[BPAB_NB_POS2] = v[2];
  endfunction

  // latch where driven, pin level where input
  function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] lat, input logic [7:0] pin);
    port_read = (dir & lat) | (~dir & pin);
  endfunction

  // address to one-hot register select, zero when unmapped
  function automatic logic [6:0] addr_sel(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    idx = a[ADDR_W-1:2];
    addr_sel = '0;
    if (a[1:0] == 2'h0) begin
      if (idx == (ADDR_W-2)'(BPAB_IDX_WIDE_DATA)) addr_sel = BPAB_R_WIDE_DATA;
      if (idx == (ADDR_W-2)'(BPAB_IDX_NARROW_DATA)) addr_sel = BPAB_R_NARROW_DATA;
      if (idx == (ADDR_W-2)'(BPAB_IDX_WIDE_DIR)) addr_sel = BPAB_R_WIDE_DIR;
      if (idx == (ADDR_W-2)'(BPAB_IDX_NARROW_DIR)) addr_sel = BPAB_R_NARROW_DIR;
      if (idx == (ADDR_W-2)'(BPAB_IDX_KEYPAD_EN)) addr_sel = BPAB_R_KEYPAD_EN;
      if (idx == (ADDR_W-2)'(BPAB_IDX_PIN_OPT)) addr_sel = BPAB_R_PIN_OPT;
      if (idx == (ADDR_W-2)'(BPAB_IDX_PULLUP)) addr_sel = BPAB_R_PULLUP;
    end
  endfunction

  // pin synchroniser
  bpab_sync_if #(.W(BPAB_SYNC_W)) sif ();
  assign sif.raw = {narrow_pin_in, wide_pin_in};
  bpab_pin_sync #(.W(BPAB_SYNC_W)) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .sif(sif)
  );
  logic [7:0] wide_sync, narrow_sync;
  assign wide_sync = sif.sync[BPAB_WIDE_W-1:0];
  assign narrow_sync = nb_pack(sif.sync[BPAB_SYNC_W-1:BPAB_WIDE_W]);

  // bus state
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic wen_q, wen_d;
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [7:0] rdata_q, rdata_d;
  logic do_write;
  logic [6:0] wsel, rsel;

  // register state
  logic [6:0] wide_dir_lo_q, wide_dir_lo_d;
  logic wide_dir7_q, wide_dir7_d;
  logic [7:0] wide_dir;
  logic [7:0] narrow_dir_q, narrow_dir_d, kbie_q, kbie_d, opt_q, opt_d, pull_q, pull_d;
  logic [7:0] wide_lat_q, wide_lat_d, narrow_lat_q, narrow_lat_d;
  assign wide_dir = {wide_dir7_q, wide_dir_lo_q};

  always_comb begin
    do_write = aw_have_q && w_have_q && !bvalid_q;
    wsel = addr_sel(awaddr_q);
    rsel = addr_sel(s_axi_araddr);
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wbyte_d = wbyte_q;
    wen_d = wen_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      wbyte_d = s_axi_wdata[7:0];
      wen_d = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (wsel == '0) ? BPAB_RESP_SLVERR : BPAB_RESP_OKAY;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = (rsel == '0) ? BPAB_RESP_SLVERR : BPAB_RESP_OKAY;
      unique case (1'b1)
        rsel[0]: rdata_d = port_read(wide_dir, wide_lat_q, wide_sync);
        rsel[1]: rdata_d = port_read(narrow_dir_q, narrow_lat_q, narrow_sync);
        rsel[2]: rdata_d = wide_dir;
        rsel[3]: rdata_d = narrow_dir_q;
        rsel[4]: rdata_d = kbie_q;
        rsel[5]: rdata_d = opt_q;
        rsel[6]: rdata_d = pull_q;
        default: rdata_d = '0;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= '0;
      wen_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= BPAB_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= BPAB_RESP_OKAY;
      rdata_q <= '0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wbyte_q <= wbyte_d;
      wen_q <= wen_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // register writes
  always_comb begin
    wide_dir_lo_d = wide_dir_lo_q;
    wide_dir7_d = wide_dir7_q;
    narrow_dir_d = narrow_dir_q;
    kbie_d = kbie_q;
    opt_d = opt_q;
    pull_d = pull_q;
    wide_lat_d = wide_lat_q;
    narrow_lat_d = narrow_lat_q;
    if (do_write && wen_q) begin
      unique case (1'b1)
        wsel[0]: wide_lat_d = wbyte_q;
        wsel[1]: narrow_lat_d = nb_pack(nb_unpack(wbyte_q));
        wsel[2]: {wide_dir7_d, wide_dir_lo_d} = wbyte_q;
        wsel[3]: narrow_dir_d = nb_pack(nb_unpack(wbyte_q));
        wsel[4]: kbie_d = wbyte_q;
        wsel[5]: opt_d = nb_pack(nb_unpack(wbyte_q));
        wsel[6]: pull_d = nb_pack(nb_unpack(wbyte_q));
        default: wide_lat_d = wide_lat_q;
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wide_dir_lo_q <= BPAB_DIR_RESET[6:0];
      narrow_dir_q <= BPAB_DIR_RESET;
      kbie_q <= BPAB_CTRL_RESET;
      opt_q <= BPAB_CTRL_RESET;
      pull_q <= BPAB_CTRL_RESET;
    end else begin
      wide_dir_lo_q <= wide_dir_lo_d;
      narrow_dir_q <= narrow_dir_d;
      kbie_q <= kbie_d;
      opt_q <= opt_d;
      pull_q <= pull_d;
    end
  end

  // direction bit 7 answers only power-on or low-voltage reset
  always_ff @(posedge clock or posedge por_lvr_rst) begin
    if (por_lvr_rst) begin
      wide_dir7_q <= BPAB_DIR_RESET[BPAB_WIDE_DIR7];
    end else begin
      wide_dir7_q <= wide_dir7_d;
    end
  end

  // data latches carry no reset
  always_ff @(posedge clock) begin
    wide_lat_q <= wide_lat_d;
    narrow_lat_q <= narrow_lat_d;
  end

  // pin drivers
  logic [7:0] wpo_d, wpoe_d, wpu_d, kbi_d;
  logic [2:0] npo_d, npoe_d, npu_d, led_d;
  logic [7:0] wpo_q, wpoe_q, wpu_q, kbi_q;
  logic [2:0] npo_q, npoe_q, npu_q, led_q;

  always_comb begin
    wpoe_d = ~(wide_dir & ~kbie_q);
    wpo_d = wide_dir & ~kbie_q & wide_lat_q;
    wpu_d = kbie_q;
    kbi_d = kbie_q & wide_sync;
    npo_d = '0;
    npoe_d = ~(nb_unpack(narrow_dir_q) & ~nb_unpack(narrow_lat_q));
    npu_d = nb_unpack(pull_q);
    led_d = nb_unpack(opt_q);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wpo_q <= '0;
      wpoe_q <= '1;
      wpu_q <= '0;
      kbi_q <= '0;
      npo_q <= '0;
      npoe_q <= '1;
      npu_q <= '0;
      led_q <= '0;
    end else begin
      wpo_q <= wpo_d;
      wpoe_q <= wpoe_d;
      wpu_q <= wpu_d;
      kbi_q <= kbi_d;
      npo_q <= npo_d;
      npoe_q <= npoe_d;
      npu_q <= npu_d;
      led_q <= led_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = {{(BPAB_DATA_W-8){1'b0}}, rdata_q};
  assign wide_pin_out = wpo_q;
  assign wide_pin_oe_n = wpoe_q;
  assign wide_pullup_en = wpu_q;
  assign keypad_irq_inputs = kbi_q;
  assign narrow_pin_out = npo_q;
  assign narrow_pin_oe_n = npoe_q;
  assign narrow_pullup_en = npu_q;
  assign led_direct_drive = led_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst || por_lvr_rst);

  sequence s_wide_read;
    s_axi_arvalid && arready_q && rsel == BPAB_R_WIDE_DATA;
  endsequence
  sequence s_wide_write;
    do_write && wen_q && wsel == BPAB_R_WIDE_DATA;
  endsequence

  a_wide_oe_dir: assert property ($past(!sys_rst) |-> wide_pin_oe_n == ~($past(wide_dir) & ~$past(kbie_q)))
    else $error("wide output enable does not follow direction");
  a_dir_reset_clear: assert property ($past(sys_rst) |-> wide_dir_lo_q == '0 && narrow_dir_q == '0)
    else $error("direction bits not cleared by reset");
  a_dir7_survives: assert property (@(posedge clock) disable iff (por_lvr_rst)
    sys_rst && !$past(do_write) |-> $stable(wide_dir7_q))
    else $error("direction bit 7 changed under plain reset");
  a_read_latch_pin: assert property (s_wide_read |=> s_axi_rvalid &&
    rdata_q == port_read($past(wide_dir), $past(wide_lat_q), $past(wide_sync)))
    else $error("wide port read mixes latch and pin wrongly");
  a_write_latch: assert property (s_wide_write |=> wide_lat_q == $past(wbyte_q) ##1 1'b1)
    else $error("wide port write did not load the latch");
  a_keypad_pullup: assert property ($past(!sys_rst) |-> wide_pullup_en == $past(kbie_q))
    else $error("keypad enable did not switch the pullup");
  a_narrow_open_drain: assert property (narrow_pin_out == '0)
    else $error("narrow port drives high");
  a_narrow_input_released: assert property (!$past(sys_rst) && $past(nb_unpack(narrow_dir_q)) == '0 |->
    narrow_pin_oe_n == '1)
    else $error("narrow port drives while set as input");
  a_led_option: assert property ($past(!sys_rst) |-> led_direct_drive == $past(nb_unpack(opt_q)))
    else $error("led drive does not follow its option bit");
  a_pullup_option: assert property ($past(!sys_rst) |-> narrow_pullup_en == $past(nb_unpack(pull_q)))
    else $error("narrow pullup does not follow its bit");
  a_write_answer: assert property (aw_have_q && w_have_q && !bvalid_q |=> s_axi_bvalid ##0 !aw_have_q)
    else $error("write response missing one clock after address and data");
endmodule // bpab_top
`default_nettype wire

/* File: testbench/bpab_pin_model.sv */
// board-side pin model: external drivers, pullups and floating lines
`timescale 1ns/1ps
`default_nettype none
module bpab_pin_model (
  input wire logic clock,
  input wire logic [bpab_pkg::BPAB_WIDE_W-1:0] wide_pin_out,
  input wire logic [bpab_pkg::BPAB_WIDE_W-1:0] wide_pin_oe_n,
  input wire logic [bpab_pkg::BPAB_WIDE_W-1:0] wide_pullup_en,
  input wire logic [bpab_pkg::BPAB_NARROW_W-1:0] narrow_pin_out,
  input wire logic [bpab_pkg::BPAB_NARROW_W-1:0] narrow_pin_oe_n,
  input wire logic [bpab_pkg::BPAB_NARROW_W-1:0] narrow_pullup_en,
  input wire logic [bpab_pkg::BPAB_WIDE_W-1:0] ext_wide_val,
  input wire logic [bpab_pkg::BPAB_WIDE_W-1:0] ext_wide_en,
  input wire logic [bpab_pkg::BPAB_NARROW_W-1:0] ext_narrow_val,
  input wire logic [bpab_pkg::BPAB_NARROW_W-1:0] ext_narrow_en,
  output var logic [bpab_pkg::BPAB_WIDE_W-1:0] wide_pin_in,
  output var logic [bpab_pkg::BPAB_NARROW_W-1:0] narrow_pin_in
);
  import bpab_pkg::*;
  // undriven lines with no pullup wander every cycle
  logic [7:0] float_q = 8'h55;
  always @(posedge clock) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < BPAB_WIDE_W; i++) begin
      if (!wide_pin_oe_n[i]) begin
        wide_pin_in[i] = wide_pin_out[i];
      end else if (ext_wide_en[i]) begin
        wide_pin_in[i] = ext_wide_val[i];
      end else begin
        wide_pin_in[i] = wide_pullup_en[i] | float_q[i];
        if (!wide_pullup_en[i]) wide_pin_in[i] = float_q[i];
      end
    end
    for (int i = 0; i < BPAB_NARROW_W; i++) begin
      if (!narrow_pin_oe_n[i]) begin
        narrow_pin_in[i] = narrow_pin_out[i];
      end else if (ext_narrow_en[i]) begin
        narrow_pin_in[i] = ext_narrow_val[i];
      end else if (narrow_pullup_en[i]) begin
        narrow_pin_in[i] = 1'b1;
      end else begin
        narrow_pin_in[i] = float_q[i];
      end
    end
  end
endmodule // bpab_pin_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// testbench: register-bus tests of the two-port gpio block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bpab_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic por_lvr_rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] wpi, wpo, woe_n, wpu, kirq, ext_wv = 8'h3c, ext_we = 8'hff;
  logic [2:0] npi, npo, noe_n, npu, led, ext_nv = 3'h0, ext_ne = 3'h0;
  int n_fail = 0;
  int n_checks = 0;
  initial begin
    forever #5 clock = ~clock;
  end
  bpab_top bpab_top_i (.clock(clock), .sys_rst(sys_rst), .por_lvr_rst(por_lvr_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .wide_pin_in(wpi), .wide_pin_out(wpo), .wide_pin_oe_n(woe_n),
    .wide_pullup_en(wpu), .keypad_irq_inputs(kirq), .narrow_pin_in(npi), .narrow_pin_out(npo),
    .narrow_pin_oe_n(noe_n), .narrow_pullup_en(npu), .led_direct_drive(led));
  bpab_pin_model bpab_pin_model_i (.clock(clock), .wide_pin_out(wpo), .wide_pin_oe_n(woe_n),
    .wide_pullup_en(wpu), .narrow_pin_out(npo), .narrow_pin_oe_n(noe_n), .narrow_pullup_en(npu),
    .ext_wide_val(ext_wv), .ext_wide_en(ext_we), .ext_narrow_val(ext_nv), .ext_narrow_en(ext_ne),
    .wide_pin_in(wpi), .narrow_pin_in(npi));
  function automatic logic [7:0] adr(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axi_write(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    int k;
    @(posedge clock);
    awaddr <= adr(idx);
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (k == 50) cmp("write answer", 32'h1, 32'h0);
    cmp("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
    int k;
    @(posedge clock);
    araddr <= adr(idx);
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (k == 50) cmp("read answer", 32'h1, 32'h0);
    cmp("rdata", {24'h0, e}, rdata);
    cmp("rresp", {30'h0, er}, {30'h0, rresp});
    rready <= 1'b0;
  endtask
  task automatic do_reset(input logic por);
    @(posedge clock);
    sys_rst <= 1'b1;
    por_lvr_rst <= por;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    por_lvr_rst <= 1'b0;
    @(posedge clock);
  endtask
  task automatic settle();
    repeat (4) @(posedge clock);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    do_reset(1'b1);
    axi_read(BPAB_IDX_WIDE_DIR, 8'h00, BPAB_RESP_OKAY);
    axi_read(BPAB_IDX_NARROW_DIR, 8'h00, BPAB_RESP_OKAY);
    cmp("wide_pin_oe_n", 32'hff, {24'h0, woe_n});
    $display("test reset done");
    axi_write(BPAB_IDX_WIDE_DATA, 8'ha5, BPAB_RESP_OKAY);
    axi_write(BPAB_IDX_WIDE_DIR, 8'hff, BPAB_RESP_OKAY);
    settle();
    cmp("wide_pin_out", 32'ha5, {24'h0, wpo});
    cmp("wide_pin_oe_n", 32'h00, {24'h0, woe_n});
    axi_read(BPAB_IDX_WIDE_DATA, 8'ha5, BPAB_RESP_OKAY);
    axi_write(BPAB_IDX_WIDE_DIR, 8'h0f, BPAB_RESP_OKAY);
    settle();
    cmp("wide_pin_oe_n", 32'hf0, {24'h0, woe_n});
    axi_read(BPAB_IDX_WIDE_DATA, 8'h35, BPAB_RESP_OKAY);
    axi_write(BPAB_IDX_WIDE_DATA, 8'h00, BPAB_RESP_OKAY);
    axi_read(BPAB_IDX_WIDE_DATA, 8'h30, BPAB_RESP_OKAY);
    $display("test wide port done");
    ext_we <= 8'h7e;
    axi_write(BPAB_IDX_KEYPAD_EN, 8'h81, BPAB_RESP_OKAY);
    settle();
    cmp("wide_pullup_en", 32'h81, {24'h0, wpu});
    cmp("wide_pin_oe_n", 32'hf1, {24'h0, woe_n});
    cmp("keypad_irq_inputs", 32'h81, {24'h0, kirq});
    axi_write(BPAB_IDX_KEYPAD_EN, 8'h00, BPAB_RESP_OKAY);
    ext_we <= 8'hff;
    $display("test keypad done");
    axi_write(BPAB_IDX_WIDE_DATA, 8'hc3, BPAB_RESP_OKAY);
    axi_write(BPAB_IDX_WIDE_DIR, 8'hff, BPAB_RESP_OKAY);
    do_reset(1'b0);
    settle();
    cmp("wide_pin_oe_n", 32'h7f, {24'h0, woe_n});
    cmp("wide_pin_out", 32'h80, {24'h0, wpo});
    axi_read(BPAB_IDX_WIDE_DIR, 8'h80, BPAB_RESP_OKAY);
    axi_read(BPAB_IDX_WIDE_DATA, 8'hbc, BPAB_RESP_OKAY);
    do_reset(1'b1);
    axi_read(BPAB_IDX_WIDE_DIR, 8'h00, BPAB_RESP_OKAY);
    axi_read(BPAB_IDX_WIDE_DATA, 8'h3c, BPAB_RESP_OKAY);
    axi_write(BPAB_IDX_WIDE_DIR, 8'hff, BPAB_RESP_OKAY);
    axi_read(BPAB_IDX_WIDE_DATA, 8'hc3, BPAB_RESP_OKAY);
    $display("test reset sources done");
    axi_write(BPAB_IDX_NARROW_DATA, 8'h02, BPAB_RESP_OKAY);
    axi_write(BPAB_IDX_NARROW_DIR, 8'h23, BPAB_RESP_OKAY);
    settle();
    cmp("narrow_pin_oe_n", 32'h2, {29'h0, noe_n});
    cmp("narrow_pin_out", 32'h0, {29'h0, npo});
    axi_read(BPAB_IDX_NARROW_DATA, 8'h02, BPAB_RESP_OKAY);
    axi_read(BPAB_IDX_NARROW_DIR, 8'h23, BPAB_RESP_OKAY);
    axi_write(BPAB_IDX_PULLUP, 8'h23, BPAB_RESP_OKAY);
    axi_write(BPAB_IDX_PIN_OPT, 8'h21, BPAB_RESP_OKAY);
    settle();
    cmp("narrow_pullup_en", 32'h7, {29'h0, npu});
    cmp("led_direct_drive", 32'h5, {29'h0, led});
    axi_read(BPAB_IDX_PULLUP, 8'h23, BPAB_RESP_OKAY);
    axi_read(BPAB_IDX_PIN_OPT, 8'h21, BPAB_RESP_OKAY);
    axi_write(BPAB_IDX_NARROW_DIR, 8'h00, BPAB_RESP_OKAY);
    ext_nv <= 3'h5;
    ext_ne <= 3'h7;
    settle();
    cmp("narrow_pin_oe_n", 32'h7, {29'h0, noe_n});
    axi_read(BPAB_IDX_NARROW_DATA, 8'h21, BPAB_RESP_OKAY);
    do_reset(1'b0);
    axi_read(BPAB_IDX_NARROW_DIR, 8'h00, BPAB_RESP_OKAY);
    cmp("narrow_pullup_en", 32'h0, {29'h0, npu});
    axi_write(BPAB_IDX_NARROW_DIR, 8'h23, BPAB_RESP_OKAY);
    axi_read(BPAB_IDX_NARROW_DATA, 8'h02, BPAB_RESP_OKAY);
    $display("test narrow port done");
    axi_read(8'h02, 8'h00, BPAB_RESP_SLVERR);
    axi_write(8'h02, 8'hff, BPAB_RESP_SLVERR);
    wstrb <= 4'h0;
    axi_write(BPAB_IDX_NARROW_DIR, 8'h00, BPAB_RESP_OKAY);
    wstrb <= 4'h1;
    axi_read(BPAB_IDX_NARROW_DIR, 8'h23, BPAB_RESP_OKAY);
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
